//--- verilog/cmcs_defines.svh
// Offsets, field positions, reset values and counts of the mode control block
// Operation
// - Debug hold plus freeze bit halts engine
// - Without debug hold, freeze bit is ignored
// - Soft reset bit resets, enters sleep, self-clears
// - Time-triggered bit switches timestamp mode
// - Timestamp counter advances once per bit
// - Auto recovery bit lets hardware leave bus-off
// - Recovery needs 128 runs of 11 recessive
// - Auto wakeup leaves sleep, clears sleep request
// - Retransmit disable bit stops automatic resend
// - Single attempt, finished flag on attempt end
// - Overwrite enabled: full FIFO frame overwrites
// - Overwrite disabled: full FIFO frame dropped
// - Order bit picks identifier or request order
// - Sleep entered only after current frame ends
// - Init request bit enters and leaves init
// - State flag clears after 11 recessive bits
// - Control register resets to 0x0001_0002
// - Status register resets to 0x0000_0C02
// - Status shows pin level and last sample
// - Status bit 9 shows receiving activity
// - Status bit 8 shows transmitting activity
`ifndef CMCS_DEFINES_SVH
`define CMCS_DEFINES_SVH
`define CMCS_OFF_CONTROL 8'h00
`define CMCS_OFF_STATUS 8'h04
`define CMCS_CONTROL_RESET 32'h0001_0002
`define CMCS_STATUS_RESET 32'h0000_0C02
`define CMCS_BIT_DFZ 16
`define CMCS_BIT_SOFT_RESET_REQ 15
`define CMCS_BIT_TTC 7
`define CMCS_BIT_AUTO_BUSOFF_RECOVER 6
`define CMCS_BIT_AWU 5
`define CMCS_BIT_ARD 4
`define CMCS_BIT_RX_OVERWRITE_DISABLE 3
`define CMCS_BIT_TFO 2
`define CMCS_BIT_SLP 1
`define CMCS_BIT_INIT 0
`define CMCS_RECESSIVE_RUN 11
`define CMCS_RECOVERY_RUNS 128
`endif

//--- verilog/cmcs_pkg.sv
// Types shared by the mode control block
package cmcs_pkg;
  typedef enum logic [1:0] {
    CMCS_SLEEP = 2'b00,
    CMCS_INIT = 2'b01,
    CMCS_SYNC = 2'b10,
    CMCS_NORMAL = 2'b11
  } cmcs_mode_e;
  typedef struct packed {
    logic debug_freeze_en;
    logic time_triggered_en;
    logic auto_busoff_recover;
    logic auto_wakeup_en;
    logic no_retransmit;
    logic rx_overwrite_disable;
    logic tx_order_fifo;
    logic slpReq;
    logic initReq;
  } cmcs_ctl_s;
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic lastSample;
    logic [3:0] run;
    logic run11;
  } cmcs_mon_s;
  typedef struct packed {
    logic [15:0] count;
  } cmcs_stamp_s;
endpackage : cmcs_pkg

//--- verilog/cmcs_bit_if.sv
// Bit-level signals between the core and its two helpers
`timescale 1ns/1ps
`default_nettype none
interface cmcs_bit_if;
  logic bitTick;
  logic ttEnable;
  logic freeze;
  logic swReset;
  logic rxLevel;
  logic lastSample;
  logic run11;
  logic [15:0] timestamp;
  modport core (output bitTick, ttEnable, freeze, swReset, input rxLevel, lastSample, run11, timestamp);
  modport monitor (input bitTick, swReset, output rxLevel, lastSample, run11);
  modport stamp (input bitTick, ttEnable, freeze, swReset, output timestamp);
endinterface : cmcs_bit_if
`default_nettype wire

//--- verilog/cmcs_rx_monitor.sv
// RX pin synchroniser, sample register and recessive run detector
`timescale 1ns/1ps
`default_nettype none
`include "cmcs_defines.svh"
module cmcs_rx_monitor import cmcs_pkg::*; (
  input wire logic clk, // Device clock
  input wire logic rst_b, // Async reset, active low
  input wire logic ce, // Clock enable
  input wire logic canRxPin, // Raw RX pin
  cmcs_bit_if.monitor bus // Core link
);
  cmcs_mon_s q, d;
  // Only sync2 looks at sync1; run counts recessive samples at bit ticks
  always_comb begin
    d = q;
    d.sync1 = canRxPin;
    d.sync2 = q.sync1;
    d.run11 = 1'b0;
    if (bus.swReset) begin
      d.run = 4'h0;
    end else if (bus.bitTick) begin
      d.lastSample = q.sync2;
      if (!q.sync2) begin
        d.run = 4'h0;
      end else if (q.run == 4'(`CMCS_RECESSIVE_RUN - 1)) begin
        d.run = 4'h0;
        d.run11 = 1'b1;
      end else begin
        d.run = q.run + 4'h1;
      end
    end
  end
  // Bus idles recessive, so the sampled levels reset high
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '{sync1: 1'b1, sync2: 1'b1, lastSample: 1'b1, run: 4'h0, run11: 1'b0};
    end else if (ce) begin
      q <= d;
    end
  end
  assign bus.rxLevel = q.sync2;
  assign bus.lastSample = q.lastSample;
  assign bus.run11 = q.run11;
endmodule : cmcs_rx_monitor
`default_nettype wire

//--- verilog/cmcs_stamp_counter.sv
// Free running bit-time counter for frame timestamps
`timescale 1ns/1ps
`default_nettype none
module cmcs_stamp_counter import cmcs_pkg::*; (
  input wire logic clk, // Device clock
  input wire logic rst_b, // Async reset, active low
  input wire logic ce, // Clock enable
  cmcs_bit_if.stamp bus // Core link
);
  cmcs_stamp_s q, d;
  // Counts only in time-triggered mode, and holds while frozen
  always_comb begin
    d = q;
    if (bus.swReset) begin
      d.count = 16'h0000;
    end else if (bus.ttEnable && bus.bitTick && !bus.freeze) begin
      d.count = q.count + 16'h0001;
    end
  end
  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end
  assign bus.timestamp = q.count;
endmodule : cmcs_stamp_counter
`default_nettype wire

//--- verilog/cmcs_top.sv
// Mode control, register file and status of the CAN controller
`timescale 1ns/1ps
`default_nettype none
`include "cmcs_defines.svh"
module cmcs_top import cmcs_pkg::*; (
  input wire logic clk, // Device clock, 50 MHz
  input wire logic rst_b, // Async reset, active low
  input wire logic ce, // Clock enable, freezes all state
  input wire logic canRxPin, // RX pin from transceiver
  input wire logic debugHoldSignal, // Debug hold from debug unit
  input wire logic bitTick, // Sample point strobe from bit timing
  input wire logic txActive, // Engine is transmitting
  input wire logic rxActive, // Engine is receiving
  input wire logic busOffEnter, // Error logic enters bus-off
  input wire logic txAttemptEnd, // A transmit attempt ended
  input wire logic txAttemptOk, // That attempt succeeded
  input wire logic rxFrameValid, // A received frame is ready to store
  input wire logic rxFifoFull, // Target receive FIFO is full
  input wire logic regSel, // Register access strobe
  input wire logic regWrite, // Write when 1, read when 0
  input wire logic [7:0] regAddr, // Byte address
  input wire logic [31:0] regWdata, // Write data
  output logic [31:0] regRdata, // Read data
  output logic regRdValid, // Read data valid
  output logic engineEnable, // Engine may take part on the bus
  output logic engineHalt, // Engine stops for debug
  output logic engineReset, // Engine reset pulse
  output logic noRetransmit, // Automatic resend disabled
  output logic txOrderFifo, // Request order instead of identifier
  output logic timeTriggeredEn, // Timestamp mode on
  output logic [15:0] timestamp, // Bit-time timestamp
  output logic busOffActive, // Bus-off state
  output logic busOffRecovered, // Leaving bus-off pulse
  output logic mailboxFinishedSet, // Set mailbox finished flag
  output logic txRetry, // Queue the frame again
  output logic rxFrameStore, // Write frame to free FIFO slot
  output logic rxFrameOverwrite, // Write frame over the newest slot
  output logic rxFrameDrop, // Discard the incoming frame
  output logic sleepStateFlag, // Sleep working state
  output logic initStateFlag // Initial working state
);

  // Whole state of the core in one record
  typedef struct packed {
    cmcs_ctl_s ctl;
    cmcs_mode_e mode;
    logic sleepFlag;
    logic initFlag;
    logic busOff;
    logic recoverArm;
    logic sawInit;
    logic [6:0] runCount;
    logic recovered;
    logic rsFlag;
    logic tsFlag;
    logic [31:0] rdata;
    logic rdValid;
    logic engEn;
    logic halt;
    logic engRst;
    logic mbxDone;
    logic retry;
    logic store;
    logic overwrite;
    logic drop;
  } cmcs_core_s;

  // Control word to record
  function automatic cmcs_ctl_s decodeCtl(input logic [31:0] w);
    cmcs_ctl_s c;
    c.debug_freeze_en = w[`CMCS_BIT_DFZ];
    c.time_triggered_en = w[`CMCS_BIT_TTC];
    c.auto_busoff_recover = w[`CMCS_BIT_AUTO_BUSOFF_RECOVER];
    c.auto_wakeup_en = w[`CMCS_BIT_AWU];
    c.no_retransmit = w[`CMCS_BIT_ARD];
    c.rx_overwrite_disable = w[`CMCS_BIT_RX_OVERWRITE_DISABLE];
    c.tx_order_fifo = w[`CMCS_BIT_TFO];
    c.slpReq = w[`CMCS_BIT_SLP];
    c.initReq = w[`CMCS_BIT_INIT];
    return c;
  endfunction : decodeCtl

  // Record to control word; reserved and self-clearing bits read 0
  function automatic logic [31:0] encodeCtl(input cmcs_ctl_s c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`CMCS_BIT_DFZ] = c.debug_freeze_en;
    w[`CMCS_BIT_TTC] = c.time_triggered_en;
    w[`CMCS_BIT_AUTO_BUSOFF_RECOVER] = c.auto_busoff_recover;
    w[`CMCS_BIT_AWU] = c.auto_wakeup_en;
    w[`CMCS_BIT_ARD] = c.no_retransmit;
    w[`CMCS_BIT_RX_OVERWRITE_DISABLE] = c.rx_overwrite_disable;
    w[`CMCS_BIT_TFO] = c.tx_order_fifo;
    w[`CMCS_BIT_SLP] = c.slpReq;
    w[`CMCS_BIT_INIT] = c.initReq;
    return w;
  endfunction : encodeCtl

  // State after power-on and after soft reset
  function automatic cmcs_core_s resetState();
    cmcs_core_s s;
    logic [31:0] st;
    s = '0;
    st = `CMCS_STATUS_RESET;
    s.ctl = decodeCtl(`CMCS_CONTROL_RESET);
    s.mode = CMCS_SLEEP;
    s.sleepFlag = st[`CMCS_BIT_SLP];
    s.initFlag = st[`CMCS_BIT_INIT];
    return s;
  endfunction : resetState

  localparam cmcs_core_s CoreReset = resetState();

  cmcs_core_s q, d;
  cmcs_bit_if bus ();

  logic hitCtl;
  logic hitStat;
  logic busy;
  logic wrCtl;
  logic swReset;
  logic [31:0] statusWord;

  // Address decode; software only does full word accesses
  assign hitCtl = regAddr == `CMCS_OFF_CONTROL;
  assign hitStat = regAddr == `CMCS_OFF_STATUS;
  assign wrCtl = regSel && regWrite && hitCtl;
  assign swReset = wrCtl && regWdata[`CMCS_BIT_SOFT_RESET_REQ];
  assign busy = txActive || rxActive;

  // Status word; the pin level passes the monitor synchroniser first
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[11] = bus.rxLevel;
    statusWord[10] = bus.lastSample;
    statusWord[9] = q.rsFlag;
    statusWord[8] = q.tsFlag;
    statusWord[`CMCS_BIT_SLP] = q.sleepFlag;
    statusWord[`CMCS_BIT_INIT] = q.initFlag;
  end

  // Next state of the core
  always_comb begin
    d = q;
    d.rdValid = 1'b0;
    d.engRst = 1'b0;
    d.recovered = 1'b0;
    d.mbxDone = 1'b0;
    d.retry = 1'b0;
    d.store = 1'b0;
    d.overwrite = 1'b0;
    d.drop = 1'b0;

    // Reserved bits are simply not stored
    if (wrCtl) begin
      d.ctl = decodeCtl(regWdata);
    end

    // Working mode machine works from the stored request bits
    case (q.mode)
      CMCS_NORMAL: begin
        if (q.ctl.initReq && !busy) begin
          d.mode = CMCS_INIT;
          d.initFlag = 1'b1;
          d.sleepFlag = 1'b0;
        end else if (q.ctl.slpReq && !busy) begin
          d.mode = CMCS_SLEEP;
          d.sleepFlag = 1'b1;
          d.initFlag = 1'b0;
        end
      end
      CMCS_INIT: begin
        if (!q.ctl.initReq) begin
          if (q.ctl.slpReq) begin
            d.mode = CMCS_SLEEP;
            d.sleepFlag = 1'b1;
            d.initFlag = 1'b0;
          end else begin
            d.mode = CMCS_SYNC;
          end
        end
      end
      CMCS_SLEEP: begin
        if (q.ctl.initReq) begin
          d.mode = CMCS_INIT;
          d.initFlag = 1'b1;
          d.sleepFlag = 1'b0;
        end else if (q.ctl.auto_wakeup_en && !bus.rxLevel) begin
          // Wake clear beats a same-cycle software write
          d.ctl.slpReq = 1'b0;
          d.mode = CMCS_SYNC;
        end else if (!q.ctl.slpReq) begin
          d.mode = CMCS_SYNC;
        end
      end
      CMCS_SYNC: begin
        if (q.ctl.initReq) begin
          d.mode = CMCS_INIT;
          d.initFlag = 1'b1;
          d.sleepFlag = 1'b0;
        end else if (q.ctl.slpReq) begin
          d.mode = CMCS_SLEEP;
          d.sleepFlag = 1'b1;
          d.initFlag = 1'b0;
        end else if (bus.run11) begin
          d.mode = CMCS_NORMAL;
          d.sleepFlag = 1'b0;
          d.initFlag = 1'b0;
        end
      end
      default: begin
        d.mode = CMCS_SLEEP;
      end
    endcase

    // Bus-off entry and recovery; entry outranks a finishing count
    if (busOffEnter) begin
      d.busOff = 1'b1;
      d.recoverArm = q.ctl.auto_busoff_recover;
      d.sawInit = 1'b0;
      d.runCount = 7'h00;
    end else if (q.busOff) begin
      if (!q.recoverArm) begin
        // Manual path: software passes through init and back out
        if (q.ctl.auto_busoff_recover) begin
          d.recoverArm = 1'b1;
        end else if (q.mode == CMCS_INIT) begin
          d.sawInit = 1'b1;
        end else if (q.sawInit) begin
          d.recoverArm = 1'b1;
        end
      end else if (bus.run11) begin
        if (q.runCount == 7'(`CMCS_RECOVERY_RUNS - 1)) begin
          d.busOff = 1'b0;
          d.recovered = 1'b1;
          d.runCount = 7'h00;
        end else begin
          d.runCount = q.runCount + 7'h01;
        end
      end
    end

    // Engine gating; freeze only counts while debug hold is up
    d.halt = debugHoldSignal && q.ctl.debug_freeze_en;
    d.engEn = (q.mode == CMCS_NORMAL) && !q.busOff;

    // Activity flags follow the engine one cycle late
    d.rsFlag = rxActive;
    d.tsFlag = txActive;

    // Transmit attempt outcome; a failed attempt resends only if allowed
    if (txAttemptEnd) begin
      if (txAttemptOk || q.ctl.no_retransmit) begin
        d.mbxDone = 1'b1;
      end else begin
        d.retry = 1'b1;
      end
    end

    // Receive FIFO policy when a frame arrives
    if (rxFrameValid) begin
      if (!rxFifoFull) begin
        d.store = 1'b1;
      end else if (q.ctl.rx_overwrite_disable) begin
        d.drop = 1'b1;
      end else begin
        d.overwrite = 1'b1;
      end
    end

    // Register read, answered one cycle after the strobe
    if (regSel && !regWrite) begin
      d.rdValid = 1'b1;
      if (hitCtl) begin
        d.rdata = encodeCtl(q.ctl);
      end else if (hitStat) begin
        d.rdata = statusWord;
      end else begin
        d.rdata = 32'h0000_0000;
      end
    end

    // Soft reset wins over everything else this cycle
    if (swReset) begin
      d = CoreReset;
      d.engRst = 1'b1;
    end
  end

  // State register; clock enable holds everything
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= CoreReset;
    end else if (ce) begin
      q <= d;
    end
  end

  // Core side of the helper link
  assign bus.bitTick = bitTick;
  assign bus.ttEnable = q.ctl.time_triggered_en;
  assign bus.freeze = q.halt;
  // Helpers clear on the write edge itself, so timestamp reads 0 with engineReset
  assign bus.swReset = swReset;

  // RX pin watcher
  cmcs_rx_monitor uMonitor (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .canRxPin(canRxPin),
    .bus(bus)
  );

  // Timestamp source
  cmcs_stamp_counter uStamp (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .bus(bus)
  );

  // Outputs straight from the state register, timestamp from the stamp counter register
  assign regRdata = q.rdata;
  assign regRdValid = q.rdValid;
  assign engineEnable = q.engEn;
  assign engineHalt = q.halt;
  assign engineReset = q.engRst;
  assign noRetransmit = q.ctl.no_retransmit;
  assign txOrderFifo = q.ctl.tx_order_fifo;
  assign timeTriggeredEn = q.ctl.time_triggered_en;
  assign timestamp = bus.timestamp;
  assign busOffActive = q.busOff;
  assign busOffRecovered = q.recovered;
  assign mailboxFinishedSet = q.mbxDone;
  assign txRetry = q.retry;
  assign rxFrameStore = q.store;
  assign rxFrameOverwrite = q.overwrite;
  assign rxFrameDrop = q.drop;
  assign sleepStateFlag = q.sleepFlag;
  assign initStateFlag = q.initFlag;

endmodule : cmcs_top
`default_nettype wire

//--- verification/cmcs_top_properties.sv
// Port-level assertions for the CAN mode control block
`timescale 1ns/1ps
`default_nettype none
`include "cmcs_defines.svh"
module cmcs_top_properties (
  input wire logic clk, // Clock
  input wire logic rst_b, // Reset
  input wire logic ce, // In
  input wire logic bitTick, // In
  input wire logic txActive, // In
  input wire logic rxActive, // In
  input wire logic debugHoldSignal, // In
  input wire logic busOffEnter, // In
  input wire logic txAttemptEnd, // In
  input wire logic txAttemptOk, // In
  input wire logic rxFrameValid, // In
  input wire logic rxFifoFull, // In
  input wire logic regSel, // In
  input wire logic regWrite, // In
  input wire logic [7:0] regAddr, // In
  input wire logic [31:0] regWdata, // In
  input wire logic [31:0] regRdata, // Out
  input wire logic engineHalt, // Out
  input wire logic engineReset, // Out
  input wire logic noRetransmit, // Out
  input wire logic timeTriggeredEn, // Out
  input wire logic [15:0] timestamp, // Out
  input wire logic busOffActive, // Out
  input wire logic mailboxFinishedSet, // Out
  input wire logic txRetry, // Out
  input wire logic rxFrameStore, // Out
  input wire logic rxFrameOverwrite, // Out
  input wire logic rxFrameDrop, // Out
  input wire logic sleepStateFlag // Out
);
  logic swr;
  logic rdStat;
  logic [1:0] up_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Soft reset write and status read decodes
  assign swr = ce && regSel && regWrite && regAddr == 8'h00 && regWdata[`CMCS_BIT_SOFT_RESET_REQ];
  assign rdStat = ce && regSel && !regWrite && regAddr == 8'h04;
  // Status history is trusted only once any reset has settled
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) up_q <= 2'h0;
    else if (swr) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end
  hold_off_run_a: assert property (ce && !debugHoldSignal |=> !engineHalt)
    else $error("halt without debug hold");
  halt_freeze_a: assert property (ce && engineHalt && debugHoldSignal && !swr |=> $stable(timestamp))
    else $error("timestamp moved while halted");
  stamp_step_a: assert property (ce && bitTick && timeTriggeredEn && !engineHalt && !debugHoldSignal && !swr
    |=> timestamp == $past(timestamp) + 16'h0001)
    else $error("timestamp did not step");
  soft_reset_a: assert property (swr |=> engineReset && sleepStateFlag && timestamp == 16'h0000 ##1 !engineReset)
    else $error("soft reset effect wrong");
  tx_ok_a: assert property (ce && txAttemptEnd && txAttemptOk |=> mailboxFinishedSet && !txRetry)
    else $error("good attempt not finished");
  tx_fail_a: assert property (ce && txAttemptEnd && !txAttemptOk
    |=> mailboxFinishedSet == $past(noRetransmit) && txRetry != $past(noRetransmit))
    else $error("failed attempt handling wrong");
  rx_space_a: assert property (ce && rxFrameValid && !rxFifoFull |=> rxFrameStore && !rxFrameOverwrite && !rxFrameDrop)
    else $error("frame not stored");
  rx_full_a: assert property (ce && rxFrameValid && rxFifoFull |=> !rxFrameStore && (rxFrameOverwrite ^ rxFrameDrop))
    else $error("full fifo policy wrong");
  sleep_idle_a: assert property ($rose(sleepStateFlag) && !engineReset
    |-> (!$past(txActive) && !$past(rxActive)) || (!$past(txActive, 2) && !$past(rxActive, 2)))
    else $error("sleep entered mid frame");
  busoff_enter_a: assert property (ce && busOffEnter |=> busOffActive)
    else $error("bus-off not entered");
  stat_tx_a: assert property (rdStat && up_q == 2'h3 && $stable(txActive) && txActive == $past(txActive, 2)
    |=> regRdata[8] == $past(txActive))
    else $error("status transmit bit wrong");
endmodule : cmcs_top_properties
bind cmcs_top cmcs_top_properties i_cmcs_top_properties (.clk, .rst_b, .ce, .bitTick, .txActive, .rxActive,
  .debugHoldSignal, .busOffEnter, .txAttemptEnd, .txAttemptOk, .rxFrameValid, .rxFifoFull, .regSel, .regWrite,
  .regAddr, .regWdata, .regRdata, .engineHalt, .engineReset, .noRetransmit, .timeTriggeredEn, .timestamp,
  .busOffActive, .mailboxFinishedSet, .txRetry, .rxFrameStore, .rxFrameOverwrite, .rxFrameDrop, .sleepStateFlag);
`default_nettype wire

//--- verification/cmcs_can_node.sv
// Remote CAN nodes as seen through the transceiver, with sample point strobe
`timescale 1ns/1ps
`default_nettype none
module cmcs_can_node #(parameter int BIT_CYC = 4) (
  input wire logic clk, // Device clock
  input wire logic rst_b, // Async reset, active low
  input wire logic dominant, // Next bit is dominant
  output logic canRxPin, // Bus level, 1 recessive
  output logic bitTick // Last cycle of each bit
);
  logic [7:0] cnt_q;
  // Level changes only at bit boundaries so a whole bit is seen after sync
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 8'h00;
      canRxPin <= 1'b1;
      bitTick <= 1'b0;
    end else begin
      cnt_q <= (cnt_q == 8'(BIT_CYC - 1)) ? 8'h00 : cnt_q + 8'h01;
      bitTick <= cnt_q == 8'(BIT_CYC - 2);
      if (cnt_q == 8'(BIT_CYC - 1)) canRxPin <= ~dominant;
    end
  end
endmodule : cmcs_can_node
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the CAN mode control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0, rst_b = 1'b0, dom = 1'b0, debugHoldSignal = 1'b0, txActive = 1'b0, rxActive = 1'b0;
  logic busOffEnter = 1'b0, txAttemptEnd = 1'b0, txAttemptOk = 1'b0, rxFrameValid = 1'b0, rxFifoFull = 1'b0;
  logic regSel = 1'b0, regWrite = 1'b0, ce = 1'b1, vld, rstSeen;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0000_0000, regRdata, rd;
  logic canRxPin, bitTick, regRdValid, engineEnable, engineHalt, engineReset, noRetransmit, txOrderFifo;
  logic timeTriggeredEn, busOffActive, mailboxFinishedSet, txRetry, rxFrameStore, rxFrameOverwrite, rxFrameDrop;
  logic sleepStateFlag, initStateFlag, busOffRecovered;
  logic [15:0] timestamp, t0;
  int mismatches = 0, samplesChecked = 0, cycles = 0;
  // Clock and remote bus
  always #10 clk = ~clk;
  cmcs_can_node i_cmcs_can_node (.clk, .rst_b, .dominant(dom), .canRxPin, .bitTick);
  cmcs_top i_cmcs_top (.clk, .rst_b, .ce, .canRxPin, .debugHoldSignal, .bitTick, .txActive, .rxActive,
    .busOffEnter, .txAttemptEnd, .txAttemptOk, .rxFrameValid, .rxFifoFull, .regSel, .regWrite, .regAddr,
    .regWdata, .regRdata, .regRdValid, .engineEnable, .engineHalt, .engineReset, .noRetransmit, .txOrderFifo,
    .timeTriggeredEn, .timestamp, .busOffActive, .busOffRecovered, .mailboxFinishedSet, .txRetry, .rxFrameStore,
    .rxFrameOverwrite, .rxFrameDrop, .sleepStateFlag, .initStateFlag);
  task automatic giveVerdict();
    $display("Checks %0d, mismatches %0d", samplesChecked, mismatches);
    if (mismatches == 0 && samplesChecked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : giveVerdict
  // Hang guard, a little above the seventeen thousand or so cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      giveVerdict();
    end
  end
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic chkWord(logic [31:0] got, logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chkWord
  task automatic chkBit(logic got, logic exp);
    chkWord({31'h0, got}, {31'h0, exp});
  endtask : chkBit
  // One access, then an idle cycle so the strobe never toggles twice at once
  task automatic regAccess(logic w, logic [7:0] a, logic [31:0] d);
    regSel = 1'b1;
    regWrite = w;
    regAddr = a;
    regWdata = d;
    tick();
    rd = regRdata;
    vld = regRdValid;
    rstSeen = engineReset;
    regSel = 1'b0;
    tick();
  endtask : regAccess
  task automatic wr(logic [31:0] d);
    regAccess(1'b1, 8'h00, d);
  endtask : wr
  task automatic rdChk(logic [7:0] a, logic [31:0] e);
    regAccess(1'b0, a, 32'h0000_0000);
    chkBit(vld, 1'b1);
    chkWord(rd, e);
  endtask : rdChk
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask : pulse
  // First tick still carries the old level, then n ticks of the new one
  task automatic bits(int n, logic d);
    dom = d;
    repeat (n + 1) begin
      @(negedge clk);
      while (bitTick !== 1'b1) @(negedge clk);
    end
    tick();
  endtask : bits
  initial begin
    tick(4);
    rst_b = 1'b1;
    rdChk(8'h00, 32'h0001_0002);
    rdChk(8'h04, 32'h0000_0C02);
    regAccess(1'b1, 8'h04, 32'h0000_0000);
    rdChk(8'h08, 32'h0000_0000);
    rdChk(8'h04, 32'h0000_0C02);
    bits(1, 1'b1);
    wr(32'h0001_0000);
    bits(10, 1'b0);
    chkBit(sleepStateFlag, 1'b1);
    bits(0, 1'b0);
    tick(4);
    chkBit(sleepStateFlag, 1'b0);
    chkBit(engineEnable, 1'b1);
    txAttemptOk = 1'b1;
    pulse(txAttemptEnd);
    chkBit(mailboxFinishedSet, 1'b1);
    txAttemptOk = 1'b0;
    // Both settings of the policy bits, last pass leaves them set
    for (int i = 0; i < 2; i++) begin
      wr(32'h0001_0000 | (i[0] ? 32'h0000_009C : 32'h0000_0000));
      chkBit(noRetransmit, i[0]);
      chkBit(txOrderFifo, i[0]);
      chkBit(timeTriggeredEn, i[0]);
      pulse(txAttemptEnd);
      chkBit(mailboxFinishedSet, i[0]);
      chkBit(txRetry, !i[0]);
      rxFifoFull = 1'b1;
      pulse(rxFrameValid);
      chkBit(rxFrameOverwrite, !i[0]);
      chkBit(rxFrameDrop, i[0]);
      rxFifoFull = 1'b0;
      tick();
      pulse(rxFrameValid);
      chkBit(rxFrameStore, 1'b1);
    end
    t0 = timestamp;
    bits(4, 1'b0);
    chkWord({16'h0, timestamp}, {16'h0, t0 + 16'h0005});
    debugHoldSignal = 1'b1;
    tick(2);
    chkBit(engineHalt, 1'b1);
    t0 = timestamp;
    bits(2, 1'b0);
    chkWord({16'h0, timestamp}, {16'h0, t0});
    wr(32'h0000_0080);
    chkBit(engineHalt, 1'b0);
    debugHoldSignal = 1'b0;
    wr(32'h0001_0001);
    tick(2);
    chkBit(initStateFlag, 1'b1);
    bits(1, 1'b1);
    wr(32'h0001_0000);
    bits(11, 1'b0);
    tick(4);
    chkBit(initStateFlag, 1'b0);
    txActive = 1'b1;
    rxActive = 1'b1;
    wr(32'h0001_0002);
    tick(4);
    chkBit(sleepStateFlag, 1'b0);
    rdChk(8'h04, 32'h0000_0F00);
    txActive = 1'b0;
    rxActive = 1'b0;
    tick(3);
    chkBit(sleepStateFlag, 1'b1);
    rdChk(8'h04, 32'h0000_0C02);
    wr(32'h0001_0022);
    bits(1, 1'b1);
    rdChk(8'h00, 32'h0001_0020);
    bits(11, 1'b0);
    tick(4);
    chkBit(sleepStateFlag, 1'b0);
    // First pass leaves bus-off by software through init, second by hardware
    for (int i = 0; i < 2; i++) begin
      wr(i[0] ? 32'h0001_0040 : 32'h0001_0001);
      pulse(busOffEnter);
      chkBit(busOffActive, 1'b1);
      if (!i[0]) begin
        bits(1408, 1'b0);
        chkBit(busOffActive, 1'b1);
        bits(1, 1'b1);
        wr(32'h0001_0000);
      end
      bits(1, 1'b1);
      bits(1407, 1'b0);
      chkBit(busOffActive, 1'b1);
      bits(0, 1'b0);
      tick();
      chkBit(busOffActive, 1'b0);
      chkBit(busOffRecovered, 1'b1);
    end
    // A write while the clock enable is low must not land
    ce = 1'b0;
    wr(32'h0001_0001);
    ce = 1'b1;
    rdChk(8'h00, 32'h0001_0040);
    wr(32'h0000_8000);
    chkBit(rstSeen, 1'b1);
    chkBit(sleepStateFlag, 1'b1);
    chkWord({16'h0, timestamp}, 32'h0000_0000);
    rdChk(8'h00, 32'h0001_0002);
    giveVerdict();
  end
endmodule : testbench
`default_nettype wire
